/* File: src/dsr_core.sv */
// ddr2 device-side command decode, burst sequencing, strobe and termination control
`timescale 1ns/10ps
`include "dsr_cfg.svh"
module dsr_core
	import dsr_pkg::*;
#(
	parameter logic X16_ORG = 1'b1
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [2:0] ba_in,
	input wire logic [13:0] addr_in,
	input wire logic odt_in,
	output logic dqs_oe_out,
	output logic dqs_n_oe_out,
	output logic [1:0] strobe_lane_out,
	output logic dm_rdqs_oe_out,
	output logic dm_is_rdqs_out,
	output logic term_on_out,
	output logic [3:0] term_group_out,
	output logic burst_active_out,
	output logic burst_write_out,
	output logic [2:0] burst_bank_out,
	output logic [13:0] burst_row_out,
	output logic [9:0] burst_col_out,
	output logic [2:0] burst_beat_out,
	output logic auto_pre_out,
	output logic [7:0] open_banks_out,
	output logic dll_on_out,
	output logic init_done_out,
	output logic cmd_err_out
);
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	dsr_bank_if bif ();
	dsr_cmd_t cmd;
	logic cmd_ok;

	// chip select high masks the whole command
	assign cmd = cs_n_in ? DSR_CMD_NOP : dsr_cmd_t'({ras_n_in, cas_n_in, we_n_in});
	assign cmd_ok = cke_in && !cs_n_in;

	// next column of a burst; sequential wraps inside block, interleaved xors
	function automatic logic [9:0] beat_col(input logic [9:0] start, input logic [2:0] beat,
		input logic bl8, input logic ilv);
		logic [2:0] low;
		low = ilv ? (start[2:0] ^ beat) : 3'(start[2:0] + beat);
		if (bl8) begin
			beat_col = {start[9:3], low};
		end else begin
			beat_col = {start[9:2], low[1:0]};
		end
	endfunction

	// ------------------------------------------------------------
	// mode registers and init tracking
	// ------------------------------------------------------------
	logic [13:0] mr_ff, nxt_mr, emr1_ff, nxt_emr1;
	logic [7:0] dll_cnt_ff, nxt_dll_cnt;
	logic ocd_dflt_ff, nxt_ocd_dflt;
	logic init_ff, nxt_init;
	logic dll_on_ff, nxt_dll_on;
	logic mrs_hit;

	assign mrs_hit = cmd_ok && cmd == DSR_CMD_MRS && ba_in[2] == 1'b0;

	// init is complete once calibration default is entered then exited late enough
	always_comb begin
		nxt_mr = mr_ff;
		nxt_emr1 = emr1_ff;
		nxt_dll_cnt = dll_cnt_ff;
		nxt_ocd_dflt = ocd_dflt_ff;
		nxt_init = init_ff;
		nxt_dll_on = dll_on_ff;
		if (dll_on_ff && dll_cnt_ff != 8'(`DSR_DLL_LOCK_CLKS)) begin
			nxt_dll_cnt = dll_cnt_ff + 8'h01;
		end
		if (mrs_hit && ba_in[1:0] == `DSR_SEL_MR) begin
			nxt_mr = addr_in;
		end
		if (mrs_hit && ba_in[1:0] == `DSR_SEL_EMR1) begin
			nxt_emr1 = addr_in;
			nxt_dll_on = !addr_in[`DSR_EMR_DLL_BIT];
			if (addr_in[`DSR_EMR_DLL_BIT] || !dll_on_ff) begin
				nxt_dll_cnt = 8'h00;
			end
			if (addr_in[`DSR_EMR_OCD_MSB:`DSR_EMR_OCD_LSB] == `DSR_OCD_DEFAULT) begin
				nxt_ocd_dflt = 1'b1;
			end else if (addr_in[`DSR_EMR_OCD_MSB:`DSR_EMR_OCD_LSB] == `DSR_OCD_EXIT &&
				ocd_dflt_ff && dll_cnt_ff == 8'(`DSR_DLL_LOCK_CLKS)) begin
				nxt_init = 1'b1;
				nxt_ocd_dflt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mr_ff <= `DSR_MR_RST;
			emr1_ff <= `DSR_EMR_RST;
			dll_cnt_ff <= 8'h00;
			ocd_dflt_ff <= 1'b0;
			init_ff <= 1'b0;
			dll_on_ff <= 1'b0;
		end else begin
			mr_ff <= nxt_mr;
			emr1_ff <= nxt_emr1;
			dll_cnt_ff <= nxt_dll_cnt;
			ocd_dflt_ff <= nxt_ocd_dflt;
			init_ff <= nxt_init;
			dll_on_ff <= nxt_dll_on;
		end
	end

	// ------------------------------------------------------------
	// burst sequencer
	// ------------------------------------------------------------
	dsr_state_t st_ff, nxt_st;
	logic [2:0] beat_ff, nxt_beat, bank_ff, nxt_bank;
	logic [9:0] col0_ff, nxt_col0;
	logic ap_ff, nxt_ap, err_ff, nxt_err;
	logic bl8, ilv, last_beat, open_hit;

	assign bl8 = mr_ff[`DSR_MR_BL_MSB:`DSR_MR_BL_LSB] == `DSR_BL8_CODE;
	assign ilv = mr_ff[`DSR_MR_BT_BIT];
	assign last_beat = beat_ff == (bl8 ? 3'h7 : 3'h3);
	assign open_hit = bif.open_mask[ba_in];
	assign bif.rd_bank = ba_in; // row of the opened bank feeds the burst view
	assign bif.rd_en = cmd_ok && cmd inside {DSR_CMD_RD, DSR_CMD_WR} && open_hit && init_ff;

	// bank table writes: activate opens, precharge closes one or all
	always_comb begin
		bif.wr_en = 1'b0;
		bif.wr_open = 1'b0;
		bif.clr_all = 1'b0;
		bif.wr_bank = ba_in;
		bif.wr_row = addr_in;
		if (cmd_ok && cmd == DSR_CMD_ACT && init_ff) begin
			bif.wr_en = 1'b1;
			bif.wr_open = 1'b1;
		end else if (cmd_ok && cmd == DSR_CMD_PRE) begin
			bif.clr_all = addr_in[`DSR_AP_BIT];
			bif.wr_en = !addr_in[`DSR_AP_BIT];
		end else if (st_ff != DSR_ST_IDLE && last_beat && ap_ff) begin
			bif.wr_en = 1'b1;
			bif.wr_bank = bank_ff;
		end
	end

	// one beat per clock; a read or write to an open bank after init interrupts the running burst
	always_comb begin
		nxt_st = st_ff;
		nxt_beat = beat_ff;
		nxt_bank = bank_ff;
		nxt_col0 = col0_ff;
		nxt_ap = ap_ff;
		nxt_err = 1'b0;
		if (st_ff != DSR_ST_IDLE) begin
			nxt_beat = beat_ff + 3'h1;
			if (last_beat) begin
				nxt_st = DSR_ST_IDLE;
				nxt_beat = 3'h0;
			end
		end
		if (cmd_ok && (cmd == DSR_CMD_RD || cmd == DSR_CMD_WR)) begin
			if (open_hit && init_ff) begin
				nxt_st = (cmd == DSR_CMD_RD) ? DSR_ST_RD : DSR_ST_WR;
				nxt_beat = 3'h0;
				nxt_bank = ba_in;
				nxt_col0 = addr_in[9:0];
				nxt_ap = addr_in[`DSR_AP_BIT];
			end else begin
				nxt_err = 1'b1;
			end
		end
		if (cmd_ok && cmd == DSR_CMD_ACT && !init_ff) begin
			nxt_err = 1'b1;
		end
		if (mrs_hit && bif.open_mask != 8'h00) begin
			nxt_err = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_ff <= DSR_ST_IDLE;
			beat_ff <= 3'h0;
			bank_ff <= 3'h0;
			col0_ff <= 10'h000;
			ap_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			beat_ff <= nxt_beat;
			bank_ff <= nxt_bank;
			col0_ff <= nxt_col0;
			ap_ff <= nxt_ap;
			err_ff <= nxt_err;
		end
	end

	dsr_bank_mem u_bank (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.bif(bif)
	);

	// ------------------------------------------------------------
	// output registers: strobe, termination, burst view
	// ------------------------------------------------------------
	logic rd_nxt, odt_en, rdqs_en, term_nxt;
	logic [3:0] tgrp_ff;
	logic [9:0] col_ff;
	logic dqs_oe_ff, dqsn_oe_ff, rdqs_oe_ff, rdqs_sel_ff, term_ff, act_ff, wr_ff;

	assign rd_nxt = nxt_st == DSR_ST_RD;
	assign odt_en = nxt_emr1[`DSR_EMR_RTT0_BIT] || nxt_emr1[`DSR_EMR_RTT1_BIT];
	assign rdqs_en = !X16_ORG && nxt_emr1[`DSR_EMR_RDQS_BIT];
	// termination never on while this device drives the bus
	assign term_nxt = odt_en && odt_in && !rd_nxt;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			dqs_oe_ff <= 1'b0;
			dqsn_oe_ff <= 1'b0;
			rdqs_oe_ff <= 1'b0;
			rdqs_sel_ff <= 1'b0;
			term_ff <= 1'b0;
			tgrp_ff <= 4'h0;
			act_ff <= 1'b0;
			wr_ff <= 1'b0;
			col_ff <= 10'h000;
		end else begin
			// device drives only on reads; writes leave the strobe to the controller
			dqs_oe_ff <= rd_nxt;
			dqsn_oe_ff <= rd_nxt && !nxt_emr1[`DSR_EMR_NDQS_BIT];
			rdqs_oe_ff <= rd_nxt && rdqs_en;
			rdqs_sel_ff <= rdqs_en;
			term_ff <= term_nxt;
			// x8 has one strobe and one mask, so only the data group is reported
			tgrp_ff <= X16_ORG ? {4{term_nxt}} : {3'h0, term_nxt};
			act_ff <= nxt_st != DSR_ST_IDLE;
			wr_ff <= nxt_st == DSR_ST_WR;
			col_ff <= beat_col(nxt_col0, nxt_beat, bl8, ilv);
		end
	end

	assign dqs_oe_out = dqs_oe_ff;
	assign dqs_n_oe_out = dqsn_oe_ff;
	assign strobe_lane_out = X16_ORG ? 2'h3 : 2'h1;
	assign dm_rdqs_oe_out = rdqs_oe_ff;
	assign dm_is_rdqs_out = rdqs_sel_ff;
	assign term_on_out = term_ff;
	assign term_group_out = tgrp_ff;
	assign burst_active_out = act_ff;
	assign burst_write_out = wr_ff;
	assign burst_bank_out = bank_ff;
	assign burst_row_out = bif.rd_row;
	assign burst_col_out = col_ff;
	assign burst_beat_out = beat_ff;
	assign auto_pre_out = ap_ff;
	assign open_banks_out = bif.open_mask;
	assign dll_on_out = dll_on_ff;
	assign init_done_out = init_ff;
	assign cmd_err_out = err_ff;
endmodule // dsr_core

/* File: src/dsr_cfg.svh */
// constants for the ddr2 device-side command and strobe logic
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH
// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define DSR_MR_BL_LSB 0
`define DSR_MR_BL_MSB 2
`define DSR_MR_BT_BIT 3
`define DSR_MR_DLLRST_BIT 8
`define DSR_BL4_CODE 3'h2
`define DSR_BL8_CODE 3'h3
// ------------------------------------------------------------
// extended mode register 1 fields
// ------------------------------------------------------------
`define DSR_EMR_DLL_BIT 0
`define DSR_EMR_RTT0_BIT 2
`define DSR_EMR_RTT1_BIT 6
`define DSR_EMR_OCD_LSB 7
`define DSR_EMR_OCD_MSB 9
`define DSR_EMR_NDQS_BIT 10
`define DSR_EMR_RDQS_BIT 11
`define DSR_EMR_QOFF_BIT 12
`define DSR_OCD_DEFAULT 3'h7
`define DSR_OCD_EXIT 3'h0
// ------------------------------------------------------------
// register selects and reset values
// ------------------------------------------------------------
`define DSR_SEL_MR 2'h0
`define DSR_SEL_EMR1 2'h1
`define DSR_SEL_EMR2 2'h2
`define DSR_SEL_EMR3 2'h3
`define DSR_AP_BIT 10
`define DSR_MR_RST 14'h0000
`define DSR_EMR_RST 14'h0000
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DSR_CLK_MHZ 40
`define DSR_DLL_LOCK_CLKS 200
`define DSR_STABLE_US 200
`define DSR_STABLE_CYC (`DSR_STABLE_US * `DSR_CLK_MHZ)
`define DSR_CKE_NOP_NS 400
`define DSR_CKE_NOP_CYC ((`DSR_CKE_NOP_NS * `DSR_CLK_MHZ + 999) / 1000)
`endif

/* File: src/dsr_pkg.sv */
// types for the ddr2 device-side command and strobe logic
package dsr_pkg;
	typedef enum logic [2:0] {
		DSR_CMD_NOP = 3'h7,
		DSR_CMD_ACT = 3'h3,
		DSR_CMD_RD = 3'h5,
		DSR_CMD_WR = 3'h4,
		DSR_CMD_PRE = 3'h2,
		DSR_CMD_REF = 3'h1,
		DSR_CMD_MRS = 3'h0,
		DSR_CMD_BST = 3'h6
	} dsr_cmd_t;
	typedef enum logic [1:0] {
		DSR_ST_IDLE = 2'h0,
		DSR_ST_RD = 2'h1,
		DSR_ST_WR = 2'h2
	} dsr_state_t;
endpackage

/* File: src/dsr_bank_if.sv */
// bank row table request and answer carrier
`timescale 1ns/10ps
interface dsr_bank_if;
	logic wr_en;
	logic [2:0] wr_bank;
	logic [13:0] wr_row;
	logic wr_open;
	logic clr_all;
	logic [7:0] open_mask;
	logic rd_en;
	logic [2:0] rd_bank;
	logic [13:0] rd_row;
	modport ctl (output wr_en, output wr_bank, output wr_row, output wr_open, output clr_all,
		output rd_en, output rd_bank, input open_mask, input rd_row);
	modport mem (input wr_en, input wr_bank, input wr_row, input wr_open, input clr_all,
		input rd_en, input rd_bank, output open_mask, output rd_row);
endinterface

/* File: src/dsr_bank_mem.sv */
// per-bank open row memory with registered open flags
`timescale 1ns/10ps
module dsr_bank_mem (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	dsr_bank_if.mem bif
);
	logic [13:0] row_ff [0:7];
	logic [13:0] rd_row_ff;
	logic [13:0] nxt_rd_row;
	logic [7:0] open_ff;
	logic [7:0] nxt_open;

	// open flags: precharge all wipes every bank
	always_comb begin
		nxt_open = open_ff;
		if (bif.clr_all) begin
			nxt_open = 8'h00;
		end else if (bif.wr_en) begin
			nxt_open[bif.wr_bank] = bif.wr_open;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			open_ff <= 8'h00;
		end else begin
			open_ff <= nxt_open;
		end
	end

	// row store needs no reset, flags guard it
	always_ff @(posedge clk_in) begin
		if (bif.wr_en && bif.wr_open) begin
			row_ff[bif.wr_bank] <= bif.wr_row;
		end
	end

	// row read for a starting burst; registered so the row lines up with the first beat
	always_comb begin
		nxt_rd_row = rd_row_ff;
		if (bif.rd_en) begin
			nxt_rd_row = row_ff[bif.rd_bank];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_row_ff <= 14'h0000;
		end else begin
			rd_row_ff <= nxt_rd_row;
		end
	end

	assign bif.open_mask = open_ff;
	assign bif.rd_row = rd_row_ff;
endmodule // dsr_bank_mem

/* File: tb/dsr_core_properties.sv */
// assertions on the ddr2 core ports
`timescale 1ns/10ps
module dsr_core_properties
	import dsr_pkg::*;
#(
	parameter logic X16_ORG = 1'b1
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [2:0] ba_in,
	input wire logic [13:0] addr_in,
	input wire logic odt_in,
	input wire logic dqs_oe_out,
	input wire logic [1:0] strobe_lane_out,
	input wire logic term_on_out,
	input wire logic [3:0] term_group_out,
	input wire logic burst_active_out,
	input wire logic burst_write_out,
	input wire logic [9:0] burst_col_out,
	input wire logic [2:0] burst_beat_out,
	input wire logic auto_pre_out,
	input wire logic [7:0] open_banks_out,
	input wire logic init_done_out,
	input wire logic cmd_err_out
);
	// ------
	// command decode seen at the pins
	// ------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic go;
	logic rw;
	logic ap;
	logic [2:0] cmd;
	logic [9:0] col;
	assign go = cke_in && !cs_n_in;
	assign cmd = {ras_n_in, cas_n_in, we_n_in};
	assign rw = go && (cmd == DSR_CMD_RD || cmd == DSR_CMD_WR);
	assign col = addr_in[9:0];
	assign ap = addr_in[10];
	// refusals show as a pulse on the next edge
	a_act_before_init: assert property (go && cmd == DSR_CMD_ACT && !init_done_out |=> cmd_err_out)
		else $error("early activate not flagged");
	a_closed_bank: assert property (rw && !open_banks_out[ba_in] |=> cmd_err_out)
		else $error("access to closed bank not flagged");
	a_mode_open: assert property (go && cmd == DSR_CMD_MRS && open_banks_out != 8'h00 |=> cmd_err_out)
		else $error("mode write with open bank not flagged");
	a_read_start: assert property (go && cmd == DSR_CMD_RD && init_done_out && open_banks_out[ba_in]
		|=> burst_active_out && dqs_oe_out && !burst_write_out)
		else $error("read burst did not start with strobe");
	a_start_col: assert property (rw && init_done_out && open_banks_out[ba_in]
		|=> burst_col_out == $past(col) && auto_pre_out == $past(ap))
		else $error("burst start column or precharge flag wrong");
	a_write_quiet: assert property (burst_write_out |-> !dqs_oe_out)
		else $error("strobe driven during write");
	a_lane_map: assert property (strobe_lane_out == (X16_ORG ? 2'h3 : 2'h1))
		else $error("strobe lane map wrong");
	a_odt_low_off: assert property (!odt_in |=> !term_on_out)
		else $error("termination on without request");
	a_term_groups: assert property (X16_ORG && term_on_out |-> term_group_out == 4'hf)
		else $error("termination group incomplete");
	a_beat_step: assert property (burst_active_out && !rw ##1 burst_active_out
		|-> burst_beat_out == $past(burst_beat_out) + 3'h1)
		else $error("burst beat did not advance");
	a_deselect_idle: assert property (cs_n_in && !burst_active_out |=> !burst_active_out)
		else $error("deselected command started a burst");
	c_read: cover property (go && cmd == DSR_CMD_RD && init_done_out);
	c_term: cover property (term_on_out);
	c_auto_pre: cover property (burst_active_out && auto_pre_out);
endmodule // dsr_core_properties
bind dsr_core dsr_core_properties #(.X16_ORG(X16_ORG)) u_dsr_core_properties (.*);

/* File: tb/dsr_ctl_model.sv */
// controller-side driver for the ddr2 core command pins
`timescale 1ns/10ps
`include "dsr_cfg.svh"
module dsr_ctl_model
	import dsr_pkg::*;
(
	input wire logic clk_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic [2:0] cmd_out,
	output logic [2:0] ba_out,
	output logic [13:0] addr_out,
	output logic odt_out
);
	// ------
	// power-up levels and command issue
	// ------
	initial begin
		cke_out = 1'b0;
		odt_out = 1'b0;
		cs_n_out = 1'b1;
		cmd_out = DSR_CMD_NOP;
		ba_out = 3'h0;
		addr_out = 14'h0000;
	end
	// 200 us is 8000 clocks at 25 ns; clock runs throughout
	task power_up();
		repeat (`DSR_STABLE_CYC) @(posedge clk_in);
		#1 cke_out = 1'b1;
		repeat (`DSR_CKE_NOP_CYC) @(posedge clk_in);
	endtask
	// termination request level, called just after an edge
	task set_odt(input logic lvl);
		odt_out = lvl;
	endtask
	// one command for one edge, then deselect with a changed address
	task send(input dsr_cmd_t cmd, input logic [2:0] ba, input logic [13:0] addr, input logic cs_n);
		@(posedge clk_in);
		#1;
		cs_n_out = cs_n;
		cmd_out = cmd;
		ba_out = ba;
		addr_out = addr;
		@(posedge clk_in);
		#1;
		cs_n_out = 1'b1;
		cmd_out = DSR_CMD_NOP;
		addr_out = ~addr;
	endtask
endmodule // dsr_ctl_model

/* File: tb/dsr_core_tb.sv */
// self-checking bench for the ddr2 device-side core
`timescale 1ns/10ps
module dsr_core_tb import dsr_pkg::*;;
	// ------
	// stimulus rows and design hookup
	// ------
	typedef struct packed {
		dsr_cmd_t cmd;
		logic [2:0] ba;
		logic [13:0] addr;
		logic [7:0] gap;
		logic err;
	} dsr_row_t;
	logic clk_in, sys_rst_in, cke, cs_n, odt, dqs_oe, dqs_n_oe, term_on, bact, bwr, apre, done, err;
	logic dll, rdqs16, rdqs_oe16, x8_rdqs, x8_rdqs_oe;
	logic [2:0] cmd, ba, bbank, bbeat;
	logic [13:0] addr, brow;
	logic [1:0] lane, x8_lane;
	logic [3:0] tgrp;
	logic [9:0] bcol;
	logic [7:0] openb;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	dsr_row_t rows [12];
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	dsr_ctl_model u_dsr_ctl_model (.clk_in(clk_in), .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd),
		.ba_out(ba), .addr_out(addr), .odt_out(odt));
	dsr_core #(.X16_ORG(1'b1)) u_dsr_core (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cke_in(cke),
		.cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .ba_in(ba),
		.addr_in(addr), .odt_in(odt), .dqs_oe_out(dqs_oe), .dqs_n_oe_out(dqs_n_oe),
		.strobe_lane_out(lane), .dm_rdqs_oe_out(rdqs_oe16), .dm_is_rdqs_out(rdqs16),
		.term_on_out(term_on), .term_group_out(tgrp), .burst_active_out(bact),
		.burst_write_out(bwr), .burst_bank_out(bbank), .burst_row_out(brow),
		.burst_col_out(bcol), .burst_beat_out(bbeat), .auto_pre_out(apre),
		.open_banks_out(openb), .dll_on_out(dll), .init_done_out(done), .cmd_err_out(err));
	// x8 twin on the same pins, watched for its lane map and mask pin read strobe
	dsr_core #(.X16_ORG(1'b0)) u_dsr_core_x8 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.cke_in(cke), .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]),
		.ba_in(ba), .addr_in(addr), .odt_in(odt), .dqs_oe_out(), .dqs_n_oe_out(),
		.strobe_lane_out(x8_lane), .dm_rdqs_oe_out(x8_rdqs_oe), .dm_is_rdqs_out(x8_rdqs),
		.term_on_out(), .term_group_out(), .burst_active_out(), .burst_write_out(),
		.burst_bank_out(), .burst_row_out(), .burst_col_out(), .burst_beat_out(),
		.auto_pre_out(), .open_banks_out(), .dll_on_out(), .init_done_out(), .cmd_err_out());
	// shared compare; tags sit at the call sites
	task chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// whole run is about 8500 clocks
	initial begin
		#(25 * 20000);
		miscompares++;
		wrap_up();
	end
	initial begin
		rows[0] = '{DSR_CMD_ACT, 3'h0, 14'h0000, 8'h00, 1'b1};
		rows[1] = '{DSR_CMD_PRE, 3'h0, 14'h0400, 8'h00, 1'b0};
		rows[2] = '{DSR_CMD_MRS, 3'h2, 14'h0000, 8'h00, 1'b0};
		rows[3] = '{DSR_CMD_MRS, 3'h3, 14'h0000, 8'h00, 1'b0};
		rows[4] = '{DSR_CMD_MRS, 3'h1, 14'h0004, 8'h00, 1'b0};
		rows[5] = '{DSR_CMD_MRS, 3'h0, 14'h0103, 8'h00, 1'b0};
		rows[6] = '{DSR_CMD_PRE, 3'h0, 14'h0400, 8'h00, 1'b0};
		rows[7] = '{DSR_CMD_REF, 3'h0, 14'h0000, 8'h00, 1'b0};
		rows[8] = '{DSR_CMD_REF, 3'h0, 14'h0000, 8'h00, 1'b0};
		rows[9] = '{DSR_CMD_MRS, 3'h0, 14'h0003, 8'hc8, 1'b0};
		rows[10] = '{DSR_CMD_MRS, 3'h1, 14'h0384, 8'h00, 1'b0};
		rows[11] = '{DSR_CMD_MRS, 3'h1, 14'h0004, 8'h00, 1'b0};
		sys_rst_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		chk(done === 1'b0 && openb === 8'h00 && bact === 1'b0 && dll === 1'b0, "reset state");
		chk(lane === 2'h3 && x8_lane === 2'h1, "strobe lanes");
		u_dsr_ctl_model.power_up();
		foreach (rows[i]) begin
			u_dsr_ctl_model.send(rows[i].cmd, rows[i].ba, rows[i].addr, 1'b0);
			chk(err === rows[i].err, "init error flag");
			repeat (rows[i].gap) @(posedge clk_in);
		end
		chk(done === 1'b1 && dll === 1'b1, "init complete");
		// burst of eight with both strobes driven
		u_dsr_ctl_model.send(DSR_CMD_ACT, 3'h5, 14'h1abc, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_RD, 3'h5, 14'h001c, 1'b0);
		chk(bact === 1'b1 && dqs_oe === 1'b1 && dqs_n_oe === 1'b1, "read strobes");
		chk(bbank === 3'h5 && brow === 14'h1abc && bcol === 10'h01c, "read address");
		n = 1;
		repeat (12) begin
			@(posedge clk_in);
			#1 n += (bact === 1'b1);
			if (bact === 1'b1 && n == 8) begin
				chk(bbeat === 3'h7 && bcol === 10'h01b, "last beat wraps in block");
			end
		end
		chk(n == 8, "burst length");
		u_dsr_ctl_model.send(DSR_CMD_WR, 3'h5, 14'h0408, 1'b0);
		chk(bwr === 1'b1 && dqs_oe === 1'b0 && apre === 1'b1, "write burst");
		repeat (10) @(posedge clk_in);
		u_dsr_ctl_model.send(DSR_CMD_RD, 3'h5, 14'h0000, 1'b0);
		chk(err === 1'b1, "read closed bank");
		// refusals and per-bank precharge
		u_dsr_ctl_model.send(DSR_CMD_ACT, 3'h2, 14'h0011, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_ACT, 3'h3, 14'h0022, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_RD, 3'h2, 14'h0000, 1'b1);
		chk(bact === 1'b0, "deselected read");
		u_dsr_ctl_model.send(DSR_CMD_MRS, 3'h0, 14'h0003, 1'b0);
		chk(err === 1'b1, "mode write open bank");
		u_dsr_ctl_model.send(DSR_CMD_PRE, 3'h2, 14'h0000, 1'b0);
		@(posedge clk_in);
		#1 chk(openb === 8'h08, "one bank precharge");
		u_dsr_ctl_model.set_odt(1'b1);
		repeat (2) @(posedge clk_in);
		#1 chk(term_on === 1'b1 && tgrp === 4'hf, "termination on");
		u_dsr_ctl_model.set_odt(1'b0);
		u_dsr_ctl_model.send(DSR_CMD_PRE, 3'h0, 14'h0400, 1'b0);
		@(posedge clk_in);
		#1 chk(openb === 8'h00, "precharge all");
		// termination off and single-ended strobe in mode register
		u_dsr_ctl_model.send(DSR_CMD_MRS, 3'h1, 14'h0400, 1'b0);
		u_dsr_ctl_model.set_odt(1'b1);
		repeat (2) @(posedge clk_in);
		#1 chk(term_on === 1'b0, "termination disabled");
		u_dsr_ctl_model.set_odt(1'b0);
		u_dsr_ctl_model.send(DSR_CMD_ACT, 3'h1, 14'h0005, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_RD, 3'h1, 14'h0000, 1'b0);
		chk(dqs_oe === 1'b1 && dqs_n_oe === 1'b0, "single-ended strobe");
		// x8 mask pin turns into a read strobe once emr1 asks for it; x16 never does
		repeat (8) @(posedge clk_in);
		u_dsr_ctl_model.send(DSR_CMD_PRE, 3'h0, 14'h0400, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_MRS, 3'h1, 14'h0800, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_ACT, 3'h1, 14'h0005, 1'b0);
		u_dsr_ctl_model.send(DSR_CMD_RD, 3'h1, 14'h0000, 1'b0);
		chk(x8_rdqs === 1'b1 && x8_rdqs_oe === 1'b1 && dqs_n_oe === 1'b1, "x8 read strobe");
		chk(rdqs16 === 1'b0 && rdqs_oe16 === 1'b0, "x16 keeps mask pin");
		wrap_up();
	end
endmodule // dsr_core_tb
